/* verilog/dmhbp_pkg.sv */
// Package with shared constants and types of the dual-mode host bus port.
package dmhbp_pkg;
  localparam int unsigned DMHBP_ADDR_W = 3;
  localparam int unsigned DMHBP_DATA_W = 8;
  localparam int unsigned DMHBP_NREG = 8;
  localparam int unsigned DMHBP_MCR_ADDR = 4;
  localparam int unsigned DMHBP_MCR_IRQ_EN_BIT = 3;
  localparam logic [7:0] DMHBP_REG_RST = 8'h00;
  localparam int unsigned DMHBP_CLK_NS = 25;
  localparam int unsigned DMHBP_RST_MIN_NS = 40;
  localparam int unsigned DMHBP_RST_CYC = (DMHBP_RST_MIN_NS + DMHBP_CLK_NS - 1) / DMHBP_CLK_NS;
  localparam int unsigned DMHBP_STROBE_CYC = 4;
  localparam logic DMHBP_MODE_SEP = 1'b1;
  localparam logic DMHBP_MODE_RW = 1'b0;
  typedef enum logic [1:0] {
    DMHBP_H_IDLE,
    DMHBP_H_ASSERT,
    DMHBP_H_RELEASE,
    DMHBP_H_GAP
  } dmhbp_hst_t;
endpackage

/* verilog/dmhbp_bus_if.sv */
// Interface carrying the pins between host and device.
`timescale 1ns/1ps
interface dmhbp_bus_if;
  logic mode_sep;
  logic rst_pin;
  logic chip_sel_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic [2:0] addr;
  logic [7:0] host_data_o;
  logic host_data_oe_n;
  logic [7:0] dev_data_o;
  logic dev_data_oe_n;
  logic irq_o;
  logic irq_oe_n;
  logic osc_out;
  logic txd;
  logic rxd;
  logic pump_autosleep;
  wire [7:0] data = !dev_data_oe_n ? dev_data_o : (!host_data_oe_n ? host_data_o : 8'hFF);
  modport device (
    input mode_sep, rst_pin, chip_sel_n, read_strobe_n, write_strobe_n, addr, data,
    input host_data_o, host_data_oe_n, rxd, pump_autosleep,
    output dev_data_o, dev_data_oe_n, irq_o, irq_oe_n, osc_out, txd
  );
  modport host (
    input mode_sep, data, irq_o, irq_oe_n, dev_data_o, dev_data_oe_n,
    output rst_pin, chip_sel_n, read_strobe_n, write_strobe_n, addr, host_data_o,
    output host_data_oe_n
  );
endinterface

/* verilog/dmhbp_sync3.sv */
// Three-stage input synchroniser with agreement of the last two stages.
`timescale 1ns/1ps
module dmhbp_sync3 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Data.
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } dmhbp_sy_t;
  dmhbp_sy_t st_r;
  dmhbp_sy_t st_nxt;
  logic [W-1:0] q_nxt;
  genvar g;
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.q = q_nxt;
  end
  // A bit changes once stages two and three agree.
  generate
    for (g = 0; g < W; g++) begin : g_bit
      assign q_nxt[g] = (st_r.s2[g] == st_r.s3[g]) ? st_r.s3[g] : st_r.q[g];
    end
  endgenerate
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r <= {4{INIT}};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign o_sync = st_r.q;
endmodule

/* verilog/dmhbp_device.sv */
// Device end of the dual-mode host bus port.
// Function
// - Strap selects separate-strobe or read/write-line style.
// - Reset pin polarity follows mode; clears registers.
// - Read strobe fall drives addressed register out.
// - Write strobe rise stores data to register.
// - Read strobe ignored in read/write-line mode.
// - Write strobe is direction line in that mode.
// - No transfer without chip select asserted.
// - Separate mode: interrupt high, enabled by bit three.
// - Line mode: interrupt open drain active low.
// - Host keeps enable bit zero in line mode.
// - Transmit output idles at marking level.
// - Remote holds receive line at marking idle.
// - Clock input buffered onto clock output.
// - Autosleep shuts pump in oscillator-stopped sleep.
`timescale 1ns/1ps
module dmhbp_device
  import dmhbp_pkg::*;
#(
  parameter int unsigned NREG = DMHBP_NREG
) (
  // Clock from oscillator input.
  input wire logic i_ref_clk,
  // Pins.
  dmhbp_bus_if.device bus,
  // User side.
  input wire logic i_irq_req,
  input wire logic i_tx_bit,
  input wire logic i_tx_busy,
  input wire logic i_osc_stopped,
  output logic o_rx_bit,
  output logic o_pump_off,
  output logic o_rst,
  output logic [7:0] o_mcr
);
  import dmhbp_pkg::*;
  typedef struct packed {
    logic [NREG-1:0][7:0] regs;
    logic rd_active;
    logic wr_active;
    logic [2:0] wr_addr;
    logic [7:0] rd_data;
    logic pump_off;
    logic txd;
  } dmhbp_dev_t;
  dmhbp_dev_t st_r;
  dmhbp_dev_t st_nxt;
  logic mode_sep;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic rst;
  logic [7:0] sync_q;
  logic [7:0] din_q;
  logic rd_req;
  logic wr_req;
  logic rx_q;

  // The receive pin is asynchronous and passes its own synchroniser.
  dmhbp_sync3 #(.W(1), .INIT(1'h1)) u_rx_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(1'b0),
    .i_async(bus.rxd),
    .o_sync(rx_q)
  );
  assign mode_sep = bus.mode_sep;
  // Strobes, chip select, reset pin and address pass the synchroniser.
  dmhbp_sync3 #(.W(8), .INIT(8'hFF)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(1'b0),
    .i_async({bus.chip_sel_n, bus.read_strobe_n, bus.write_strobe_n, bus.rst_pin, bus.addr,
      bus.pump_autosleep}),
    .o_sync(sync_q)
  );
  assign cs_n = sync_q[7];
  assign rd_n = sync_q[6];
  assign wr_n = sync_q[5];
  assign rst = (mode_sep == DMHBP_MODE_SEP) ? sync_q[4] : !sync_q[4];
  assign din_q = bus.data;

  // Read request: read strobe low in separate mode, direction high in line mode.
  always_comb begin
    rd_req = 1'b0;
    wr_req = 1'b0;
    if (!cs_n) begin
      if (mode_sep == DMHBP_MODE_SEP) begin
        rd_req = !rd_n;
        wr_req = !wr_n;
      end else begin
        rd_req = wr_n;
        wr_req = !wr_n;
      end
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.txd = i_tx_busy ? i_tx_bit : 1'b1;
    st_nxt.pump_off = sync_q[0] && i_osc_stopped;
    st_nxt.rd_active = rd_req;
    if (rd_req && !st_r.rd_active) begin
      st_nxt.rd_data = st_r.regs[sync_q[3:1]];
    end
    st_nxt.wr_active = wr_req;
    if (wr_req) begin
      st_nxt.wr_addr = sync_q[3:1];
    end
    if (!wr_req && st_r.wr_active) begin
      st_nxt.regs[st_r.wr_addr] = din_q;
    end
    if (rst) begin
      st_nxt.regs = '0;
      st_nxt.rd_active = 1'b0;
      st_nxt.wr_active = 1'b0;
      st_nxt.wr_addr = 3'h0;
      st_nxt.rd_data = DMHBP_REG_RST;
      st_nxt.txd = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    st_r <= st_nxt;
  end

  // Output enable low means the device drives the data bus.
  assign bus.dev_data_o = st_r.rd_data;
  assign bus.dev_data_oe_n = !(st_r.rd_active && rd_req);
  always_comb begin
    if (mode_sep == DMHBP_MODE_SEP) begin
      bus.irq_o = i_irq_req;
      bus.irq_oe_n = !st_r.regs[DMHBP_MCR_ADDR][DMHBP_MCR_IRQ_EN_BIT];
    end else begin
      bus.irq_o = 1'b0;
      bus.irq_oe_n = !i_irq_req;
    end
  end
  assign bus.osc_out = i_ref_clk;
  assign bus.txd = st_r.txd;
  assign o_rx_bit = rx_q;
  assign o_pump_off = st_r.pump_off;
  assign o_rst = rst;
  assign o_mcr = st_r.regs[DMHBP_MCR_ADDR];
endmodule

/* verilog/dmhbp_host.sv */
// Host end of the dual-mode host bus port.
`timescale 1ns/1ps
module dmhbp_host
  import dmhbp_pkg::*;
(
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Pins.
  dmhbp_bus_if.host bus,
  // User side.
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_dev_rst,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic o_irq
);
  import dmhbp_pkg::*;
  typedef struct packed {
    dmhbp_hst_t st;
    logic [3:0] cnt;
    logic we;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;
  } dmhbp_hs_t;
  dmhbp_hs_t st_r;
  dmhbp_hs_t st_nxt;
  logic active;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    case (st_r.st)
      DMHBP_H_IDLE: begin
        if (i_req) begin
          st_nxt.st = DMHBP_H_ASSERT;
          st_nxt.we = i_we;
          st_nxt.addr = i_addr;
          st_nxt.wdata = i_wdata;
          st_nxt.cnt = 4'h0;
        end
      end
      DMHBP_H_ASSERT: begin
        st_nxt.cnt = st_r.cnt + 4'h1;
        if (st_r.cnt == 4'(DMHBP_STROBE_CYC + 3)) begin
          st_nxt.rdata = bus.data;
          st_nxt.st = DMHBP_H_RELEASE;
          st_nxt.cnt = 4'h0;
        end
      end
      DMHBP_H_RELEASE: begin
        st_nxt.cnt = st_r.cnt + 4'h1;
        if (st_r.cnt == 4'(DMHBP_STROBE_CYC)) begin
          st_nxt.st = DMHBP_H_GAP;
          st_nxt.cnt = 4'h0;
        end
      end
      DMHBP_H_GAP: begin
        st_nxt.cnt = st_r.cnt + 4'h1;
        if (st_r.cnt == 4'(DMHBP_STROBE_CYC)) begin
          st_nxt.st = DMHBP_H_IDLE;
          st_nxt.done = 1'b1;
        end
      end
      default: begin
        st_nxt.st = DMHBP_H_IDLE;
      end
    endcase
    if (i_rst) begin
      st_nxt = '0;
      st_nxt.st = DMHBP_H_IDLE;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    st_r <= st_nxt;
  end

  assign active = (st_r.st == DMHBP_H_ASSERT);
  assign bus.chip_sel_n = !(active || st_r.st == DMHBP_H_RELEASE);
  assign bus.addr = st_r.addr;
  // Separate mode pulses one strobe; line mode holds the direction line.
  always_comb begin
    if (bus.mode_sep == DMHBP_MODE_SEP) begin
      bus.read_strobe_n = !(active && !st_r.we);
      bus.write_strobe_n = !(active && st_r.we);
    end else begin
      bus.read_strobe_n = 1'b1;
      bus.write_strobe_n = !(active && st_r.we);
    end
  end
  assign bus.host_data_o = st_r.wdata;
  assign bus.host_data_oe_n = !(st_r.we && st_r.st != DMHBP_H_IDLE && st_r.st != DMHBP_H_GAP);
  assign bus.rst_pin = (bus.mode_sep == DMHBP_MODE_SEP) ? i_dev_rst : !i_dev_rst;
  assign o_busy = (st_r.st != DMHBP_H_IDLE);
  assign o_done = st_r.done;
  assign o_rdata = st_r.rdata;
  always_comb begin
    if (bus.mode_sep == DMHBP_MODE_SEP) begin
      o_irq = !bus.irq_oe_n && bus.irq_o;
    end else begin
      o_irq = !bus.irq_oe_n && !bus.irq_o;
    end
  end
endmodule

/* bench/dmhbp_assertions.sv */
// Pin-level checker for the bus between the host and device ends.
`timescale 1ns/1ps
module dmhbp_assertions (
  // Clock.
  input wire logic i_ref_clk,
  // Bus pins.
  input wire logic mode_sep,
  input wire logic rst_pin,
  input wire logic chip_sel_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic dev_data_oe_n,
  input wire logic irq_o,
  input wire logic irq_oe_n,
  input wire logic osc_out,
  input wire logic txd
);
  wire logic rst_act = mode_sep ? rst_pin : !rst_pin;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (rst_act);
  sequence s_sep_rd;
    mode_sep && !chip_sel_n && !read_strobe_n;
  endsequence
  sequence s_line_rd;
    !mode_sep && !chip_sel_n && write_strobe_n;
  endsequence
  AST_RST: assert property (disable iff (1'h0) rst_act[*7] |-> txd && dev_data_oe_n)
    else $error("Active pins in reset");
  AST_NO_CS: assert property (chip_sel_n [*5] |-> dev_data_oe_n)
    else $error("Bus driven while unselected");
  AST_SEP_RD: assert property (s_sep_rd [*7] |-> !dev_data_oe_n)
    else $error("Read data not driven");
  AST_LINE_RD: assert property (s_line_rd [*7] |-> !dev_data_oe_n)
    else $error("Line read data not driven");
  AST_LINE_WR: assert property ((!mode_sep && !write_strobe_n) [*5] |-> dev_data_oe_n)
    else $error("Bus driven in line write");
  AST_SYNC: assert property (mode_sep && !chip_sel_n && $fell(read_strobe_n)
    |-> dev_data_oe_n [*2]) else $error("Strobe used before synchronising");
  AST_IRQ_OD: assert property (!mode_sep && !irq_oe_n |-> !irq_o)
    else $error("Open-drain interrupt driven high");
  AST_OSC: assert property (@(negedge i_ref_clk) osc_out)
    else $error("Clock output not following clock");
  AST_OSC_LO: assert property (@(posedge i_ref_clk) !osc_out)
    else $error("Clock output high before rising edge");
endmodule

/* bench/testbench.sv */
// Self-checking testbench joining host and device ends of the bus port.
`timescale 1ns/1ps
module testbench;
  import dmhbp_pkg::*;
  logic i_ref_clk, i_rst, i_req, i_we, i_dev_rst, i_irq_req, i_tx_bit, i_tx_busy, i_osc_stopped;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, o_rdata, o_mcr, mem [8];
  logic o_busy, o_done, o_irq, o_rx_bit, o_pump_off, o_rst;
  logic [8:0] notes [$];
  logic [8:0] nt;
  int bad_count = 0, samples_checked = 0, seed = 20, n;
  dmhbp_bus_if bus ();
  dmhbp_host dmhbp_host_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .bus(bus), .i_req(i_req),
    .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata), .i_dev_rst(i_dev_rst), .o_busy(o_busy),
    .o_done(o_done), .o_rdata(o_rdata), .o_irq(o_irq));
  dmhbp_device dmhbp_device_inst (.i_ref_clk(i_ref_clk), .bus(bus), .i_irq_req(i_irq_req),
    .i_tx_bit(i_tx_bit), .i_tx_busy(i_tx_busy), .i_osc_stopped(i_osc_stopped),
    .o_rx_bit(o_rx_bit), .o_pump_off(o_pump_off), .o_rst(o_rst), .o_mcr(o_mcr));
  dmhbp_assertions dmhbp_assertions_inst (.i_ref_clk(i_ref_clk), .mode_sep(bus.mode_sep),
    .rst_pin(bus.rst_pin), .chip_sel_n(bus.chip_sel_n), .read_strobe_n(bus.read_strobe_n),
    .write_strobe_n(bus.write_strobe_n), .dev_data_oe_n(bus.dev_data_oe_n), .irq_o(bus.irq_o),
    .irq_oe_n(bus.irq_oe_n), .osc_out(bus.osc_out), .txd(bus.txd));
  task automatic finish_test(input bit hung);
    if (hung) bad_count++;
    $display("Checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic xfer(input logic we, input logic [2:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_req <= 1'h1;
    i_we <= we;
    i_addr <= a;
    i_wdata <= d;
    if (we) mem[a] = d;
    notes.push_back({!we, mem[a]});
    @(posedge i_ref_clk);
    i_req <= 1'h0;
    @(posedge i_ref_clk);
    chk1(o_busy, 1'h1);
    n = 0;
    while (o_done !== 1'h1 && n < 40) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    if (n >= 40) finish_test(1'h1);
  endtask
  task automatic dev_reset(input logic sep);
    @(posedge i_ref_clk);
    bus.mode_sep <= sep;
    i_dev_rst <= 1'h1;
    repeat (8) @(posedge i_ref_clk);
    chk1(o_rst, 1'h1);
    i_dev_rst <= 1'h0;
    repeat (6) @(posedge i_ref_clk);
    chk1(o_rst, 1'h0);
    foreach (mem[k]) mem[k] = DMHBP_REG_RST;
  endtask
  always @(posedge i_ref_clk) begin
    if (o_done === 1'h1 && notes.size() == 0) chk(8'h01, 8'h00);
    else if (o_done === 1'h1) begin
      nt = notes.pop_front();
      if (nt[8]) chk(o_rdata, nt[7:0]);
    end
  end
  initial begin
    i_ref_clk = 1'h0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    {i_rst, i_dev_rst, i_req, i_we, i_irq_req, i_tx_bit, i_tx_busy, i_osc_stopped} = 8'hC4;
    {i_addr, i_wdata} = 11'h000;
    bus.mode_sep = DMHBP_MODE_SEP;
    bus.rxd = 1'h1;
    bus.pump_autosleep = 1'h1;
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    for (int m = 0; m < 2; m++) begin
      dev_reset(m == 0);
      chk1(bus.txd, 1'h1);
      chk1(o_rx_bit, 1'h1);
      chk1(bus.irq_oe_n, 1'h1);
      for (int a = 0; a < 8; a++) xfer(1'h1, a[2:0], 8'($random(seed)) & (m ? 8'hF7 : 8'hFF));
      xfer(1'h1, 3'h4, m ? 8'h00 : 8'h08);
      for (int a = 7; a >= 0; a--) xfer(1'h0, a[2:0], 8'h00);
      chk(o_mcr, mem[4]);
      i_irq_req <= 1'h1;
      repeat (6) @(posedge i_ref_clk);
      chk1(o_irq, 1'h1);
      chk1(bus.irq_oe_n, 1'h0);
      chk1(bus.irq_o, m == 0);
      i_irq_req <= 1'h0;
      i_osc_stopped <= m[0];
      dev_reset(m == 0);
      chk1(o_pump_off, m[0]);
      xfer(1'h0, 3'h4, 8'h00);
      bus.pump_autosleep <= 1'h0;
      repeat (6) @(posedge i_ref_clk);
      chk1(o_pump_off, 1'h0);
      bus.pump_autosleep <= 1'h1;
      $display("Mode pass %0d done", m);
    end
    finish_test(1'h0);
  end
endmodule
